// >>> logic/fss_status_bank.sv
// read-only fault summary and per-output detail status bank
// Functional notes
// - byte bit 6 set while any output unpowered
// - bits 5,4,3 are ov, oc, vin uv
// - bit 2 temperature, bit 1 comm/memory/logic
// - bit 0 flags any other status change
// - summaries gather faults from both outputs
// - word low byte equals summary byte
// - word bits 15..12 vout, output_current_fault_summary, input, maker
// - word bit 11 set when power not good
// - voltage detail: ov 7, uv 4, max 3
// - current detail: oc 7, ocuv 6, share 3
// - detail reads follow the selected page
// - host writes never change status contents
// - comm summary covers bad command, data, packet
// - temperature summary covers ot, otw, ut
`include "fss_map.svh"
module fss_status_bank (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clear_faults,
  input wire logic [1:0] rail_power_on,
  input wire logic [1:0] rail_power_good,
  input wire logic [1:0] rail_ov_fault,
  input wire logic [1:0] rail_uv_fault,
  input wire logic [1:0] rail_vmax_warn,
  input wire logic [1:0] rail_oc_fault,
  input wire logic [1:0] rail_ocuv_fault,
  input wire logic [1:0] rail_share_fault,
  input wire logic vin_ov_fault,
  input wire logic input_undervoltage_fault,
  input wire logic iin_oc_fault,
  input wire logic temp_ot_fault,
  input wire logic temp_ot_warn,
  input wire logic temp_ut_fault,
  input wire logic cml_invalid_cmd,
  input wire logic cml_invalid_data,
  input wire logic cml_packet_error,
  input wire logic cml_memory_fault,
  input wire logic cml_processor_fault,
  input wire logic cml_other_comm,
  input wire logic cml_other_logic,
  input wire logic nvm_full,
  input wire logic other_status_change,
  input wire logic page_sel,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  output logic rsp_valid,
  output fss_pkg::fss_word_t rsp_data,
  output fss_pkg::fss_rsp_t rsp_kind
);
  fss_pkg::fss_byte_t vout_detail [2];
  fss_pkg::fss_byte_t output_current_fault_summary_detail [2];

  for (genvar r = 0; r < 2; r++) begin : g_rail
    fss_rail_status u_rail (
      .clock(clock),
      .rst_n(rst_n),
      .clear_faults(clear_faults),
      .ov_fault(rail_ov_fault[r]),
      .uv_fault(rail_uv_fault[r]),
      .vmax_warn(rail_vmax_warn[r]),
      .oc_fault(rail_oc_fault[r]),
      .ocuv_fault(rail_ocuv_fault[r]),
      .share_fault(rail_share_fault[r]),
      .vout_detail(vout_detail[r]),
      .output_current_fault_summary_detail(output_current_fault_summary_detail[r])
    );
  end

  // global sticky detail flags feeding the summary
  fss_pkg::fss_byte_t input_reg;
  fss_pkg::fss_byte_t input_next;
  fss_pkg::fss_byte_t temp_reg;
  fss_pkg::fss_byte_t temp_next;
  fss_pkg::fss_byte_t cml_reg;
  fss_pkg::fss_byte_t cml_next;
  fss_pkg::fss_byte_t mfr_reg;
  fss_pkg::fss_byte_t mfr_next;
  logic other_reg;
  logic other_next;
  fss_pkg::fss_byte_t input_set;
  fss_pkg::fss_byte_t temp_set;
  fss_pkg::fss_byte_t cml_set;
  fss_pkg::fss_byte_t mfr_set;
  fss_pkg::fss_byte_t keep_mask;

  always_comb begin
    input_set = `FSS_DETAIL_RESET;
    temp_set = `FSS_DETAIL_RESET;
    cml_set = `FSS_DETAIL_RESET;
    mfr_set = `FSS_DETAIL_RESET;
    input_set[`FSS_IN_OV_BIT] = vin_ov_fault;
    input_set[`FSS_IN_UV_BIT] = input_undervoltage_fault;
    input_set[`FSS_IN_OC_BIT] = iin_oc_fault;
    temp_set[`FSS_TEMP_OT_BIT] = temp_ot_fault;
    temp_set[`FSS_TEMP_OTW_BIT] = temp_ot_warn;
    temp_set[`FSS_TEMP_UT_BIT] = temp_ut_fault;
    cml_set[`FSS_CML_BAD_CMD_BIT] = cml_invalid_cmd;
    cml_set[`FSS_CML_BAD_DATA_BIT] = cml_invalid_data;
    cml_set[`FSS_CML_PEC_BIT] = cml_packet_error;
    cml_set[`FSS_CML_MEM_BIT] = cml_memory_fault;
    cml_set[`FSS_CML_PROC_BIT] = cml_processor_fault;
    cml_set[`FSS_CML_COMM_BIT] = cml_other_comm;
    cml_set[`FSS_CML_LOGIC_BIT] = cml_other_logic;
    mfr_set[`FSS_MFR_NVM_FULL_BIT] = nvm_full;
    keep_mask = clear_faults ? `FSS_DETAIL_RESET : 8'hff;
    // set wins over clear
    input_next = ((input_reg & keep_mask) | input_set) & `FSS_INPUT_DETAIL_MASK;
    temp_next = ((temp_reg & keep_mask) | temp_set) & `FSS_TEMP_DETAIL_MASK;
    cml_next = ((cml_reg & keep_mask) | cml_set) & `FSS_CML_DETAIL_MASK;
    mfr_next = ((mfr_reg & keep_mask) | mfr_set) & `FSS_MFR_DETAIL_MASK;
    other_next = (other_reg & !clear_faults) | other_status_change;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      input_reg <= `FSS_DETAIL_RESET;
      temp_reg <= `FSS_DETAIL_RESET;
      cml_reg <= `FSS_DETAIL_RESET;
      mfr_reg <= `FSS_DETAIL_RESET;
      other_reg <= 1'b0;
    end else begin
      input_reg <= input_next;
      temp_reg <= temp_next;
      cml_reg <= cml_next;
      mfr_reg <= mfr_next;
      other_reg <= other_next;
    end
  end

  // summary assembly, global across both rails
  fss_pkg::fss_byte_t summary_byte;
  fss_pkg::fss_word_t summary_word;

  always_comb begin
    summary_byte = `FSS_DETAIL_RESET;
    summary_byte[`FSS_SB_OFF] = !(&rail_power_on);
    summary_byte[`FSS_SB_VOUT_OV] = vout_detail[0][`FSS_VOUT_OV_BIT] | vout_detail[1][`FSS_VOUT_OV_BIT];
    summary_byte[`FSS_SB_OUTPUT_CURRENT_FAULT_SUMMARY_OC] = output_current_fault_summary_detail[0][`FSS_OUTPUT_CURRENT_FAULT_SUMMARY_OC_BIT] | output_current_fault_summary_detail[1][`FSS_OUTPUT_CURRENT_FAULT_SUMMARY_OC_BIT];
    summary_byte[`FSS_SB_VIN_UV] = input_reg[`FSS_IN_UV_BIT];
    summary_byte[`FSS_SB_TEMP] = |temp_reg;
    summary_byte[`FSS_SB_CML] = |cml_reg;
    summary_byte[`FSS_SB_OTHER] = other_reg;
    summary_word = `FSS_WORD_RESET;
    summary_word[7:0] = summary_byte;
    summary_word[`FSS_SW_VOUT] = |(vout_detail[0] | vout_detail[1]);
    summary_word[`FSS_SW_OUTPUT_CURRENT_FAULT_SUMMARY] = |(output_current_fault_summary_detail[0] | output_current_fault_summary_detail[1]);
    summary_word[`FSS_SW_INPUT] = |input_reg;
    summary_word[`FSS_SW_MFR] = |mfr_reg;
    summary_word[`FSS_SW_PGOOD_N] = !(&rail_power_good);
  end

  // command port: one answer per request, next cycle
  logic rsp_valid_reg;
  logic rsp_valid_next;
  fss_pkg::fss_word_t rsp_data_reg;
  fss_pkg::fss_word_t rsp_data_next;
  fss_pkg::fss_rsp_t rsp_kind_reg;
  fss_pkg::fss_rsp_t rsp_kind_next;
  logic known_code;

  always_comb begin
    known_code = 1'b1;
    rsp_data_next = `FSS_WORD_RESET;
    case (cmd_code)
      `FSS_CMD_SUMMARY_BYTE: begin
        rsp_data_next = {8'h00, summary_byte};
      end
      `FSS_CMD_SUMMARY_WORD: begin
        rsp_data_next = summary_word;
      end
      `FSS_CMD_VOUT_DETAIL: begin
        rsp_data_next = {8'h00, vout_detail[page_sel]};
      end
      `FSS_CMD_OUTPUT_CURRENT_FAULT_SUMMARY_DETAIL: begin
        rsp_data_next = {8'h00, output_current_fault_summary_detail[page_sel]};
      end
      default: begin
        known_code = 1'b0;
      end
    endcase
    rsp_valid_next = cmd_valid;
    rsp_kind_next = fss_pkg::FSS_RSP_OK;
    if (!known_code) begin
      rsp_kind_next = fss_pkg::FSS_RSP_BAD_CMD;
      rsp_data_next = `FSS_WORD_RESET;
    end else if (cmd_write) begin
      // status is read-only: the write is refused and stores nothing
      rsp_kind_next = fss_pkg::FSS_RSP_READ_ONLY;
      rsp_data_next = `FSS_WORD_RESET;
    end
    if (!cmd_valid) begin
      rsp_kind_next = fss_pkg::FSS_RSP_OK;
      rsp_data_next = `FSS_WORD_RESET;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= `FSS_WORD_RESET;
      rsp_kind_reg <= fss_pkg::FSS_RSP_OK;
    end else begin
      rsp_valid_reg <= rsp_valid_next;
      rsp_data_reg <= rsp_data_next;
      rsp_kind_reg <= rsp_kind_next;
    end
  end

  assign rsp_valid = rsp_valid_reg;
  assign rsp_data = rsp_data_reg;
  assign rsp_kind = rsp_kind_reg;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_read(logic [7:0] code);
    cmd_valid && !cmd_write && cmd_code == code;
  endsequence

  sequence s_read_page(logic [7:0] code, logic pg);
    cmd_valid && !cmd_write && cmd_code == code && page_sel == pg && !clear_faults;
  endsequence

  a_off_bit: assert property (s_read(`FSS_CMD_SUMMARY_BYTE) and !rail_power_on[1] |=> rsp_data[6])
    else $error("off bit missing while an output is unpowered");

  a_byte_layout: assert property (s_read(`FSS_CMD_SUMMARY_BYTE) |=> rsp_valid && rsp_data[15:7] == 9'h000)
    else $error("summary byte carries bits above 6");

  a_vin_uv_bit: assert property (input_undervoltage_fault ##1 !clear_faults ##1 s_read(`FSS_CMD_SUMMARY_BYTE) |=> rsp_data[3])
    else $error("input undervoltage not shown in summary byte");

  a_temp_summary: assert property (temp_ut_fault ##1 !clear_faults ##1 s_read(`FSS_CMD_SUMMARY_BYTE) |=> rsp_data[2])
    else $error("temperature summary bit missing");

  a_cml_summary: assert property (cml_packet_error ##1 !clear_faults ##1 s_read(`FSS_CMD_SUMMARY_BYTE) |=> rsp_data[1])
    else $error("comm memory logic summary bit missing");

  a_other_change: assert property (other_status_change ##1 !clear_faults ##1 s_read(`FSS_CMD_SUMMARY_BYTE) |=> rsp_data[0])
    else $error("other status change not reported");

  a_either_rail: assert property (rail_oc_fault[1] ##1 !clear_faults ##1 s_read(`FSS_CMD_SUMMARY_BYTE) |=> rsp_data[4])
    else $error("overcurrent on second output not in summary");

  a_word_mirror: assert property (s_read(`FSS_CMD_SUMMARY_WORD) |=> rsp_data[7:0] == $past(summary_byte))
    else $error("word low byte differs from summary byte");

  a_word_upper: assert property (rail_uv_fault[0] ##1 !clear_faults ##1 s_read(`FSS_CMD_SUMMARY_WORD) |=> rsp_data[15] && rsp_data[10:7] == 4'h0)
    else $error("word voltage bit or reserved bits wrong");

  a_pgood_bit: assert property (s_read(`FSS_CMD_SUMMARY_WORD) and !rail_power_good[0] |=> rsp_data[11])
    else $error("power not good missing from word");

  a_vout_detail: assert property (s_read_page(`FSS_CMD_VOUT_DETAIL, 1'b1) and vout_detail[1][`FSS_VOUT_MAX_BIT] |=> (rsp_data & 16'hff67) == 16'h0000 && rsp_data[3])
    else $error("voltage detail layout wrong");

  a_output_current_fault_summary_detail: assert property (s_read_page(`FSS_CMD_OUTPUT_CURRENT_FAULT_SUMMARY_DETAIL, 1'b0) and output_current_fault_summary_detail[0][`FSS_OUTPUT_CURRENT_FAULT_SUMMARY_OCUV_BIT] |=> rsp_data[6] && (rsp_data & 16'hff37) == 16'h0000)
    else $error("current detail layout wrong");

  a_paged_read: assert property (s_read(`FSS_CMD_OUTPUT_CURRENT_FAULT_SUMMARY_DETAIL) |=> rsp_data[7:0] == ($past(page_sel) ? $past(output_current_fault_summary_detail[1]) : $past(output_current_fault_summary_detail[0])))
    else $error("detail read ignored page");

  a_write_refused: assert property (cmd_valid && cmd_write && cmd_code[7:2] == 6'h1e |=> rsp_valid && rsp_kind == fss_pkg::FSS_RSP_READ_ONLY)
    else $error("write to status not refused");

  a_write_keeps: assert property (cmd_valid && cmd_write && !clear_faults && !rail_share_fault[0] |=> vout_detail[0] == $past(vout_detail[0]) || $past(rail_ov_fault[0] | rail_uv_fault[0] | rail_vmax_warn[0]))
    else $error("write altered status");

  a_sum_or: assert property (s_read(`FSS_CMD_SUMMARY_WORD) and (output_current_fault_summary_detail[1] != 8'h00) |=> rsp_data[14])
    else $error("current summary not OR of details");

  a_reserved_zero: assert property (s_read_page(`FSS_CMD_VOUT_DETAIL, 1'b0) |=> rsp_data[15:8] == 8'h00 && rsp_data[6:5] == 2'b00 && rsp_data[2:0] == 3'b000)
    else $error("unused detail bits not zero");

  a_answer_once: assert property (rsp_valid |-> $past(cmd_valid))
    else $error("answer without request");

  a_bad_code: assert property (cmd_valid && cmd_code[7:2] != 6'h1e |=> rsp_valid && rsp_kind == fss_pkg::FSS_RSP_BAD_CMD && rsp_data == 16'h0000)
    else $error("unknown code not refused");

  a_set_wins: assert property (rail_ov_fault[0] && clear_faults |=> vout_detail[0][`FSS_VOUT_OV_BIT])
    else $error("clear beat a new overvoltage event");

  a_clear_drops: assert property (clear_faults && !rail_share_fault[1] |=> !output_current_fault_summary_detail[1][`FSS_OUTPUT_CURRENT_FAULT_SUMMARY_SHARE_BIT])
    else $error("share flag survived a clear");

  a_word_vin_bit: assert property (s_read(`FSS_CMD_SUMMARY_WORD) and input_reg[`FSS_IN_OV_BIT] |=> rsp_data[13])
    else $error("input fault missing from word");

  a_mfr_bit: assert property (s_read(`FSS_CMD_SUMMARY_WORD) and mfr_reg[`FSS_MFR_NVM_FULL_BIT] |=> rsp_data[12])
    else $error("maker event missing from word");

  a_powered_clear: assert property (s_read(`FSS_CMD_SUMMARY_BYTE) and rail_power_on == 2'b11 |=> !rsp_data[6])
    else $error("off bit set while both outputs powered");
endmodule : fss_status_bank

// >>> logic/fss_map.svh
// command codes, bit positions, masks and reset values of the fault summary bank
`ifndef FSS_MAP_SVH
`define FSS_MAP_SVH

`define FSS_CMD_SUMMARY_BYTE 8'h78
`define FSS_CMD_SUMMARY_WORD 8'h79
`define FSS_CMD_VOUT_DETAIL 8'h7a
`define FSS_CMD_OUTPUT_CURRENT_FAULT_SUMMARY_DETAIL 8'h7b

`define FSS_SB_OFF 6
`define FSS_SB_VOUT_OV 5
`define FSS_SB_OUTPUT_CURRENT_FAULT_SUMMARY_OC 4
`define FSS_SB_VIN_UV 3
`define FSS_SB_TEMP 2
`define FSS_SB_CML 1
`define FSS_SB_OTHER 0

`define FSS_SW_VOUT 15
`define FSS_SW_OUTPUT_CURRENT_FAULT_SUMMARY 14
`define FSS_SW_INPUT 13
`define FSS_SW_MFR 12
`define FSS_SW_PGOOD_N 11

`define FSS_VOUT_OV_BIT 7
`define FSS_VOUT_UV_BIT 4
`define FSS_VOUT_MAX_BIT 3
`define FSS_OUTPUT_CURRENT_FAULT_SUMMARY_OC_BIT 7
`define FSS_OUTPUT_CURRENT_FAULT_SUMMARY_OCUV_BIT 6
`define FSS_OUTPUT_CURRENT_FAULT_SUMMARY_SHARE_BIT 3

`define FSS_IN_OV_BIT 7
`define FSS_IN_UV_BIT 4
`define FSS_IN_OC_BIT 2
`define FSS_TEMP_OT_BIT 7
`define FSS_TEMP_OTW_BIT 6
`define FSS_TEMP_UT_BIT 4
`define FSS_CML_BAD_CMD_BIT 7
`define FSS_CML_BAD_DATA_BIT 6
`define FSS_CML_PEC_BIT 5
`define FSS_CML_MEM_BIT 4
`define FSS_CML_PROC_BIT 3
`define FSS_CML_COMM_BIT 1
`define FSS_CML_LOGIC_BIT 0
`define FSS_MFR_NVM_FULL_BIT 1

`define FSS_VOUT_DETAIL_MASK 8'h98
`define FSS_OUTPUT_CURRENT_FAULT_SUMMARY_DETAIL_MASK 8'hc8
`define FSS_INPUT_DETAIL_MASK 8'h94
`define FSS_TEMP_DETAIL_MASK 8'hd0
`define FSS_CML_DETAIL_MASK 8'hfb
`define FSS_MFR_DETAIL_MASK 8'h02

`define FSS_DETAIL_RESET 8'h00
`define FSS_WORD_RESET 16'h0000

`endif

// >>> logic/fss_pkg.sv
// types shared by the fault summary bank
package fss_pkg;
  typedef logic [7:0] fss_byte_t;
  typedef logic [15:0] fss_word_t;
  typedef enum logic [1:0] {
    FSS_RSP_OK,
    FSS_RSP_BAD_CMD,
    FSS_RSP_READ_ONLY
  } fss_rsp_t;
endpackage : fss_pkg

// >>> logic/fss_rail_status.sv
// sticky voltage and current detail flags of one output rail
`include "fss_map.svh"
module fss_rail_status (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clear_faults,
  input wire logic ov_fault,
  input wire logic uv_fault,
  input wire logic vmax_warn,
  input wire logic oc_fault,
  input wire logic ocuv_fault,
  input wire logic share_fault,
  output fss_pkg::fss_byte_t vout_detail,
  output fss_pkg::fss_byte_t output_current_fault_summary_detail
);
  fss_pkg::fss_byte_t vout_reg;
  fss_pkg::fss_byte_t vout_next;
  fss_pkg::fss_byte_t output_current_fault_summary_reg;
  fss_pkg::fss_byte_t output_current_fault_summary_next;
  fss_pkg::fss_byte_t vout_set;
  fss_pkg::fss_byte_t output_current_fault_summary_set;

  always_comb begin
    vout_set = `FSS_DETAIL_RESET;
    output_current_fault_summary_set = `FSS_DETAIL_RESET;
    vout_set[`FSS_VOUT_OV_BIT] = ov_fault;
    vout_set[`FSS_VOUT_UV_BIT] = uv_fault;
    vout_set[`FSS_VOUT_MAX_BIT] = vmax_warn;
    output_current_fault_summary_set[`FSS_OUTPUT_CURRENT_FAULT_SUMMARY_OC_BIT] = oc_fault;
    output_current_fault_summary_set[`FSS_OUTPUT_CURRENT_FAULT_SUMMARY_OCUV_BIT] = ocuv_fault;
    output_current_fault_summary_set[`FSS_OUTPUT_CURRENT_FAULT_SUMMARY_SHARE_BIT] = share_fault;
    // a new fault beats a clear in the same cycle
    vout_next = ((clear_faults ? `FSS_DETAIL_RESET : vout_reg) | vout_set) & `FSS_VOUT_DETAIL_MASK;
    output_current_fault_summary_next = ((clear_faults ? `FSS_DETAIL_RESET : output_current_fault_summary_reg) | output_current_fault_summary_set) & `FSS_OUTPUT_CURRENT_FAULT_SUMMARY_DETAIL_MASK;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      vout_reg <= `FSS_DETAIL_RESET;
      output_current_fault_summary_reg <= `FSS_DETAIL_RESET;
    end else begin
      vout_reg <= vout_next;
      output_current_fault_summary_reg <= output_current_fault_summary_next;
    end
  end

  assign vout_detail = vout_reg;
  assign output_current_fault_summary_detail = output_current_fault_summary_reg;
endmodule : fss_rail_status

// >>> test/fss_host_model.sv
// management bus host model issuing status requests to the bank
module fss_host_model (
  input wire logic clock,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic page_sel,
  input wire logic rsp_valid,
  input wire fss_pkg::fss_word_t rsp_data,
  input wire fss_pkg::fss_rsp_t rsp_kind
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    page_sel = 1'b0;
  end
  // idle gap, one-cycle strobe, answer taken once settled
  task automatic request(input logic w, input logic [7:0] code, input logic page, input int gap,
                         output logic v, output fss_pkg::fss_word_t d, output fss_pkg::fss_rsp_t k);
    repeat (gap) @(posedge clock);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_code <= code;
    page_sel <= page;
    @(posedge clock);
    cmd_valid <= 1'b0;
    // released lines show the inverse, not a stale value
    cmd_write <= ~w;
    cmd_code <= ~code;
    page_sel <= ~page;
    #1;
    v = rsp_valid;
    d = rsp_data;
    k = rsp_kind;
  endtask : request
endmodule : fss_host_model

// >>> test/test_fault_status_summary_regs.sv
// self-checking bench of the fault summary status bank
module test_fault_status_summary_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst_n, clear_faults, cmd_valid, cmd_write, page_sel, rsp_valid, page;
  logic [7:0] cmd_code;
  logic [1:0] pon, pgood;
  // ov, uv, vmax, oc, ocuv, share per rail, then input, temp, cml, nvm, other
  logic [26:0] ev, st;
  fss_pkg::fss_word_t rsp_data, w;
  fss_pkg::fss_rsp_t rsp_kind;
  int mismatches, n_compared;

  fss_status_bank uut (
    .clock(clock), .rst_n(rst_n), .clear_faults(clear_faults), .rail_power_on(pon), .rail_power_good(pgood),
    .rail_ov_fault(ev[1:0]), .rail_uv_fault(ev[3:2]), .rail_vmax_warn(ev[5:4]), .rail_oc_fault(ev[7:6]),
    .rail_ocuv_fault(ev[9:8]), .rail_share_fault(ev[11:10]), .vin_ov_fault(ev[12]), .input_undervoltage_fault(ev[13]),
    .iin_oc_fault(ev[14]), .temp_ot_fault(ev[15]), .temp_ot_warn(ev[16]), .temp_ut_fault(ev[17]),
    .cml_invalid_cmd(ev[18]), .cml_invalid_data(ev[19]), .cml_packet_error(ev[20]), .cml_memory_fault(ev[21]),
    .cml_processor_fault(ev[22]), .cml_other_comm(ev[23]), .cml_other_logic(ev[24]), .nvm_full(ev[25]),
    .other_status_change(ev[26]), .page_sel(page_sel), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_kind(rsp_kind)
  );

  fss_host_model host (
    .clock(clock), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .page_sel(page_sel),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_kind(rsp_kind)
  );

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic check(input string what, input fss_pkg::fss_word_t seen, input fss_pkg::fss_word_t exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    if (mismatches == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  function automatic fss_pkg::fss_word_t expect_read(input logic [7:0] code, input logic p);
    fss_pkg::fss_byte_t b;
    fss_pkg::fss_word_t r;
    b = {1'b0, ~&pon, |st[1:0], |st[7:6], st[13], |st[17:15], |st[24:18], st[26]};
    case (code)
      8'h78: r = {8'h00, b};
      8'h79: r = {|st[5:0], |st[11:6], |st[14:12], st[25], ~&pgood, 3'b000, b};
      8'h7a: r = {8'h00, st[p], 2'b00, st[2+p], st[4+p], 3'b000};
      8'h7b: r = {8'h00, st[6+p], st[8+p], 2'b00, st[10+p], 3'b000};
      default: r = 16'h0000;
    endcase
    return r;
  endfunction : expect_read

  task automatic xfer(input logic wr, input logic [7:0] code, input logic p, input int gap,
                      input fss_pkg::fss_word_t exp_d, input fss_pkg::fss_rsp_t exp_k);
    logic v;
    fss_pkg::fss_word_t d;
    fss_pkg::fss_rsp_t k;
    host.request(wr, code, p, gap, v, d, k);
    check("rsp_valid", 16'(v), 16'h0001);
    check($sformatf("rsp_data of %h", code), d, exp_d);
    check("rsp_kind", 16'(k), 16'(exp_k));
  endtask : xfer

  // drive events for one cycle, set live levels that hold until the next stir, track sticky state
  task automatic stir(input logic [26:0] vec, input logic clr, input logic [1:0] on, input logic [1:0] good);
    @(posedge clock);
    ev <= vec;
    clear_faults <= clr;
    pon <= on;
    pgood <= good;
    @(posedge clock);
    ev <= '0;
    clear_faults <= 1'b0;
    st = clr ? vec : (st | vec);
  endtask : stir

  task automatic read_all();
    for (int c = 0; c < 4; c++) begin
      for (int p = 0; p < 2; p++) begin
        xfer(1'b0, 8'h78 + 8'(c), 1'(p), 0, expect_read(8'h78 + 8'(c), 1'(p)), fss_pkg::FSS_RSP_OK);
      end
    end
  endtask : read_all

  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    give_verdict();
  end

  initial begin
    rst_n = 1'b0;
    clear_faults = 1'b0;
    ev = '0;
    st = '0;
    pon = 2'b11;
    pgood = 2'b11;
    mismatches = 0;
    n_compared = 0;
    void'($urandom(66));
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    read_all();
    for (int i = 0; i < 27; i++) begin
      stir(27'(1) << i, 1'b0, 2'b11, 2'b11);
      read_all();
      stir('0, 1'b1, 2'b11, 2'b11);
    end
    for (int i = 0; i < 4; i++) begin
      stir('0, 1'b0, 2'(i), 2'(3 - i));
      xfer(1'b0, 8'h79, 1'b0, 0, expect_read(8'h79, 1'b0), fss_pkg::FSS_RSP_OK);
    end
    stir(27'h7ffffff, 1'b0, 2'b01, 2'b10);
    for (int c = 0; c < 4; c++) begin
      xfer(1'b1, 8'h78 + 8'(c), 1'b1, 1, 16'h0000, fss_pkg::FSS_RSP_READ_ONLY);
    end
    read_all();
    xfer(1'b0, 8'h7c, 1'b0, 0, 16'h0000, fss_pkg::FSS_RSP_BAD_CMD);
    // event and clear in one cycle: the event survives
    stir(27'h0000201, 1'b1, 2'b11, 2'b11);
    read_all();
    repeat (60) begin
      stir(27'($urandom & $urandom), ($urandom % 4) == 0, 2'($urandom), 2'($urandom));
      page = 1'($urandom);
      w = expect_read(8'h79, page);
      xfer(1'b0, 8'h79, page, $urandom % 3, w, fss_pkg::FSS_RSP_OK);
      xfer(1'b0, 8'h78, page, 0, expect_read(8'h78, page), fss_pkg::FSS_RSP_OK);
      if (w[15]) xfer(1'b0, 8'h7a, page, 0, expect_read(8'h7a, page), fss_pkg::FSS_RSP_OK);
      if (w[14]) xfer(1'b0, 8'h7b, page, 0, expect_read(8'h7b, page), fss_pkg::FSS_RSP_OK);
    end
    stir(27'h5555555, 1'b0, 2'b11, 2'b11);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    st = '0;
    read_all();
    give_verdict();
  end
endmodule : test_fault_status_summary_regs
